// [design/frs_pkg.sv]
// constants for the resume, nop, soft reset and parameter read block
package frs_pkg;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_PSR = 8'h5a;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [5:0] BITS_OP = 6'h08;
  localparam logic [5:0] BITS_HDR = 6'h28;
  localparam logic [5:0] STEP_1 = 6'h01;
  localparam logic [5:0] STEP_4 = 6'h04;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [23:0] ADR_ONE = 24'h000001;
  localparam logic [23:0] PSP_LAST = 24'h000017;
  localparam logic [4:0] PSP_VID = 5'h10;
  localparam logic [7:0] PSP_FILL = 8'hff;
  // arbitrary neutral vendor code
  localparam logic [7:0] VENDOR_ID_DEF = 8'h5e;
  localparam logic [7:0] PSP_TAB [24] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};
  localparam int GAP_US = 1000;
  localparam int CLK_MHZ = 25;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
endpackage

// [design/frs_flash_cmd.sv]
// resume, nop, two-step soft reset and parameter-space read handling
`timescale 1ns/1ps
`default_nettype none
module frs_flash_cmd
  import frs_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter logic [7:0] VENDOR_ID = VENDOR_ID_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  input wire logic quad_cmd_mode,
  input wire logic perf_mode,
  input wire logic erase_susp_evt,
  input wire logic prog_susp_evt,
  input wire logic write_done,
  output logic so_out,
  output logic so_oe,
  output logic erase_suspended_flag,
  output logic program_suspended_flag,
  output logic busy,
  output logic reset_armed,
  output logic resume_erase,
  output logic resume_program,
  output logic write_abort,
  output logic soft_reset,
  output logic cmd_valid,
  output logic [7:0] cmd_op,
  output logic suspend_allowed
);
  localparam int GW = $clog2(GAP_CYCLES + 1);

  function automatic logic susp_ok(input logic [7:0] op);
    susp_ok = (op == OP_WRITE_ENABLE_CMD) || (op == OP_RDSR) ||
      (op == OP_READ) || (op == OP_FREAD);
  endfunction

  function automatic logic own_op(input logic [7:0] op);
    own_op = (op == OP_RESUME) || (op == OP_NOP) ||
      (op == OP_RST_ARM) || (op == OP_RST) || (op == OP_PSR);
  endfunction

  // link side, clocked by the host serial clock
  // power-up values; in reset the system side loads 0 into both toggle stages and copies the second stage into its seen copy,
  // so the frame detector expects the toggle to start at 0
  logic fresh_q = 1'b1;
  logic tog_q = 1'b0;
  logic [5:0] cnt_q;
  logic [7:0] op_q;
  logic [23:0] adr_q;
  logic [2:0] bit_q;
  logic so_q = 1'b0;
  logic oe_q = 1'b0;

  wire [5:0] cnt_b = fresh_q ? 6'h00 : cnt_q;
  wire [5:0] step = quad_cmd_mode ? STEP_4 : STEP_1;
  wire in_op = cnt_b < BITS_OP;
  wire in_hdr = cnt_b < BITS_HDR;
  // single-line mode ignores the upper data lines
  wire [7:0] op_sh = quad_cmd_mode ? {op_q[3:0], dq_in} :
    {op_q[6:0], dq_in[0]};
  wire [23:0] adr_sh = quad_cmd_mode ? {adr_q[19:0], dq_in} :
    {adr_q[22:0], dq_in[0]};
  wire in_adr = !in_op && (cnt_b < BITS_HDR - BITS_OP);
  wire data_ph = !in_hdr && (op_q == OP_PSR);
  wire data_fe = !fresh_q && (cnt_q == BITS_HDR) && (op_q == OP_PSR);
  wire [4:0] tab_i = adr_q[4:0];
  wire tab_hit = adr_q <= PSP_LAST;
  wire [7:0] tab_raw = PSP_TAB[tab_i];
  wire [7:0] tab_b = (tab_i == PSP_VID) ? VENDOR_ID : tab_raw;
  wire [7:0] cur_byte = tab_hit ? tab_b : PSP_FILL;

  // fresh marks the first edge of a frame; counters are not cleared by
  // chip select so the system side can still read them after the frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(posedge sclk) begin
    tog_q <= tog_q ^ fresh_q;
    cnt_q <= in_hdr ? cnt_b + step : cnt_b;
  end

  always_ff @(posedge sclk) begin
    if (in_op) begin
      op_q <= op_sh;
    end
  end

  always_ff @(posedge sclk) begin
    if (in_adr) begin
      adr_q <= adr_sh;
    end else if (data_ph && bit_q == BIT_LAST) begin
      adr_q <= adr_q + ADR_ONE;
    end
  end

  always_ff @(posedge sclk) begin
    bit_q <= in_hdr ? 3'h0 : bit_q + 3'h1;
  end

  // output changes on the falling edge, so the host samples it rising
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      so_q <= data_fe ? cur_byte[~bit_q] : 1'b0;
      oe_q <= data_fe;
    end
  end

  assign so_out = so_q;
  assign so_oe = oe_q;

  // system side
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tg_s1_q;
  logic tg_s2_q;
  logic tg_seen_q;
  logic esf_q;
  logic psf_q;
  logic busy_q;
  logic arm_q;
  logic res_e_q;
  logic res_p_q;
  logic abort_q;
  logic srst_q;
  logic cval_q;
  logic [7:0] cop_q;
  logic [GW-1:0] gap_q;
  logic sok_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
    end else if (ce) begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tg_s1_q <= tog_q;
      tg_s2_q <= tg_s1_q;
    end
  end

  // op and count are stable here: the serial clock has stopped
  wire cs_rise = cs_s2_q && !cs_s3_q;
  wire new_frame = tg_s2_q != tg_seen_q;
  wire done = cs_rise && new_frame;
  wire byte_ok = cnt_q == BITS_OP;
  wire got = cnt_q >= BITS_OP;
  wire one_b = done && byte_ok;
  wire susp = esf_q || psf_q;
  // no write enable state is consulted here
  wire is_resume = one_b && (op_q == OP_RESUME) &&
    !perf_mode && susp;
  wire is_arm = one_b && (op_q == OP_RST_ARM);
  wire is_rst = one_b && (op_q == OP_RST) && arm_q;
  wire clr_arm = done && got;
  wire fwd = done && got && !own_op(op_q) &&
    (!susp || susp_ok(op_q));
  // suspend events win over a clear in the same cycle
  wire esf_d = erase_susp_evt ||
    (esf_q && !is_resume && !is_rst);
  wire psf_d = prog_susp_evt ||
    (psf_q && !is_resume && !is_rst);
  wire busy_d = is_resume ||
    (busy_q && !write_done && !is_rst);
  wire arm_d = is_arm || (arm_q && !clr_arm);
  wire [GW-1:0] gap_d = is_resume ? GW'(GAP_CYCLES) :
    (gap_q != '0) ? gap_q - GW'(1) : gap_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tg_seen_q <= tg_s2_q;
    end else if (ce && cs_rise) begin
      tg_seen_q <= tg_s2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      esf_q <= 1'b0;
      psf_q <= 1'b0;
      busy_q <= 1'b0;
      arm_q <= 1'b0;
      gap_q <= '0;
    end else if (ce) begin
      esf_q <= esf_d;
      psf_q <= psf_d;
      busy_q <= busy_d;
      arm_q <= arm_d;
      gap_q <= gap_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      res_e_q <= 1'b0;
      res_p_q <= 1'b0;
      abort_q <= 1'b0;
      srst_q <= 1'b0;
      cval_q <= 1'b0;
      cop_q <= 8'h00;
      sok_q <= 1'b1;
    end else if (ce) begin
      res_e_q <= is_resume && esf_q;
      res_p_q <= is_resume && psf_q;
      abort_q <= is_rst && busy_q;
      srst_q <= is_rst;
      cval_q <= fwd;
      cop_q <= fwd ? op_q : cop_q;
      sok_q <= gap_d == '0;
    end
  end

  assign erase_suspended_flag = esf_q;
  assign program_suspended_flag = psf_q;
  assign busy = busy_q;
  assign reset_armed = arm_q;
  assign resume_erase = res_e_q;
  assign resume_program = res_p_q;
  assign write_abort = abort_q;
  assign soft_reset = srst_q;
  assign cmd_valid = cval_q;
  assign cmd_op = cop_q;
  assign suspend_allowed = sok_q;

  a_resume_clear:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && is_resume && !erase_susp_evt && !prog_susp_evt |=>
    !erase_suspended_flag && !program_suspended_flag)
    else $error("resume left a suspend flag set");

  a_resume_busy:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    resume_erase || resume_program |-> busy)
    else $error("busy not set by resume");

  a_perf_block:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && perf_mode && done |=> !resume_erase && !resume_program)
    else $error("resume taken in performance mode");

  a_nop_disarm:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && one_b && op_q == OP_NOP |=> !reset_armed && !soft_reset)
    else $error("nop did not cancel reset arm");

  a_reset_armed:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(soft_reset) |-> $past(reset_armed))
    else $error("reset without preceding arm");

  a_reset_clear:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    soft_reset |-> !busy && !reset_armed)
    else $error("soft reset left state set");

  a_reset_abort:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && is_rst && busy |=> write_abort ##1 !busy || !ce)
    else $error("running write not aborted");

  a_cs_release:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    cs_s2_q && cs_s3_q |-> !so_oe)
    else $error("output driven with chip select high");

  a_susp_set:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && erase_susp_evt |=> erase_suspended_flag)
    else $error("erase suspend flag not set");

  a_susp_filter:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && done && susp && !susp_ok(op_q) |=> !cmd_valid)
    else $error("command passed while suspended");

  a_short_drop:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && done && !got |=> !cmd_valid && !soft_reset &&
    !resume_erase && !resume_program && $stable(reset_armed))
    else $error("partial opcode acted on");
endmodule // frs_flash_cmd
`default_nettype wire

// [bench/frs_host_model.sv]
// host serial controller model driving chip select and serial clock
`timescale 1ns/1ps
`default_nettype none
module frs_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq_in,
  output logic quad_cmd_mode,
  input wire logic so_out
);
  logic [191:0] rd_q;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_in = 4'h0;
    quad_cmd_mode = 1'b0;
    rd_q = '0;
  end
  // mode only changes between frames, never inside one
  task automatic set_quad(input logic q);
    quad_cmd_mode = q;
  endtask
  // hdr is left aligned; clock runs only inside the frame
  task automatic frame(input logic [63:0] hdr, input int nbits, input int nrd);
    int step;
    step = quad_cmd_mode ? 4 : 1;
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i += step) begin
      dq_in = quad_cmd_mode ? hdr[63-i -: 4] : {3'h5, hdr[63-i]};
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    for (int i = 0; i < 8 * nrd; i++) begin
      #80 sclk = 1'b1;
      rd_q = {rd_q[190:0], so_out};
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    // released lines must not keep a stale value
    dq_in = ~dq_in;
    // end between system clock edges so the caller's next edge wait is exact
    #190;
  endtask
endmodule // frs_host_model
`default_nettype wire

// [bench/test_frs_flash_cmd.sv]
// self-checking bench for the command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_frs_flash_cmd;
  import frs_pkg::*;
  localparam logic [7:0] VID = 8'ha7; // arbitrary vendor code
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic perf_mode = 1'b0;
  logic erase_susp_evt = 1'b0;
  logic prog_susp_evt = 1'b0;
  logic write_done = 1'b0;
  wire logic sclk, cs_n, quad_cmd_mode, so_out, so_oe, busy, reset_armed;
  wire logic erase_suspended_flag, program_suspended_flag, cmd_valid;
  wire logic resume_erase, resume_program, write_abort, soft_reset;
  wire logic suspend_allowed;
  wire logic [3:0] dq_in;
  wire logic [7:0] cmd_op;
  int num_errors = 0;
  int total_checks = 0;
  int n_re = 0;
  int n_rp = 0;
  int n_ab = 0;
  int n_sr = 0;
  int n_cv = 0;
  frs_flash_cmd #(.GAP_CYCLES(20), .VENDOR_ID(VID)) uut (.sys_clk, .rst_b,
    .ce, .sclk, .cs_n, .dq_in, .quad_cmd_mode, .perf_mode, .erase_susp_evt,
    .prog_susp_evt, .write_done, .so_out, .so_oe, .erase_suspended_flag,
    .program_suspended_flag, .busy, .reset_armed, .resume_erase,
    .resume_program, .write_abort, .soft_reset, .cmd_valid, .cmd_op,
    .suspend_allowed);
  frs_host_model host (.sclk, .cs_n, .dq_in, .quad_cmd_mode, .so_out);
  always #20 sys_clk = ~sys_clk;
  // pulses last one cycle, so count them rather than poll
  always @(posedge sys_clk) begin
    n_re += resume_erase;
    n_rp += resume_program;
    n_ab += write_abort;
    n_sr += soft_reset;
    n_cv += cmd_valid;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // effects land on the third rising system clock edge after chip select rises
  task automatic op(input logic [7:0] x);
    host.frame({x, 56'h0}, 8, 0);
    tick(6);
  endtask
  task automatic t_resume;
    // a low enable freezes the flag; the event is taken once it returns
    ce = 1'b0;
    erase_susp_evt = 1'b1;
    tick(2);
    `CHK(erase_suspended_flag, 1'b0)
    ce = 1'b1;
    tick(1);
    erase_susp_evt = 1'b0;
    tick(1);
    `CHK(erase_suspended_flag, 1'b1)
    perf_mode = 1'b1;
    op(OP_RESUME);
    `CHK(n_re, 0)
    perf_mode = 1'b0;
    op(OP_RESUME); // no write enable sent before
    `CHK(n_re, 1)
    `CHK(erase_suspended_flag, 1'b0)
    `CHK(busy, 1'b1)
    `CHK(suspend_allowed, 1'b0)
    tick(12);
    `CHK(suspend_allowed, 1'b0)
    tick(1);
    `CHK(suspend_allowed, 1'b1)
    write_done = 1'b1;
    tick(1);
    write_done = 1'b0;
    tick(2);
    `CHK(busy, 1'b0)
  endtask
  task automatic t_reset;
    prog_susp_evt = 1'b1;
    tick(1);
    prog_susp_evt = 1'b0;
    op(8'hc7);
    `CHK(n_cv, 0)
    `CHK(program_suspended_flag, 1'b1)
    op(OP_RDSR);
    `CHK(n_cv, 1)
    `CHK(cmd_op, OP_RDSR)
    op(OP_RESUME);
    `CHK(n_rp, 1)
    `CHK(program_suspended_flag, 1'b0)
    op(OP_RST_ARM);
    `CHK(reset_armed, 1'b1)
    op(OP_NOP);
    `CHK(reset_armed, 1'b0)
    `CHK(busy, 1'b1)
    op(OP_RST);
    `CHK(n_sr, 0)
    op(OP_RST_ARM);
    host.frame({OP_RST, 56'h0}, 4, 0);
    tick(6);
    `CHK(reset_armed, 1'b1)
    `CHK(n_sr, 0)
    op(OP_RDSR);
    `CHK(reset_armed, 1'b0)
    host.set_quad(1'b1);
    op(OP_RST_ARM);
    `CHK(reset_armed, 1'b1)
    op(OP_RST);
    `CHK(n_sr, 1)
    `CHK(n_ab, 1)
    `CHK(busy, 1'b0)
    host.set_quad(1'b0);
  endtask
  task automatic t_read;
    host.frame({OP_PSR, 24'h0, 8'h0, 24'h0}, 40, 24);
    `CHK(host.rd_q[191:64], 128'h53464450_000101ff_00000109_300000ff)
    `CHK(host.rd_q[63:0], {VID, 56'h00010460_0000ff})
    host.frame({OP_PSR, 24'h000016, 8'h0, 24'h0}, 40, 3);
    `CHK(host.rd_q[23:0], 24'h00ffff)
    `CHK(so_oe, 1'b0)
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #2ms;
    num_errors++;
    $display("CHECK FAILED t=%0t run timed out", $time);
    report_and_stop;
  end
  initial begin
    tick(12);
    rst_b = 1'b1;
    tick(2);
    `CHK(suspend_allowed, 1'b1)
    `CHK(reset_armed, 1'b0)
    t_resume;
    t_reset;
    t_read;
    report_and_stop;
  end
endmodule // test_frs_flash_cmd
`default_nettype wire
